// ---- core/ifs_format_switch.sv ----
// Format switch, latch clear and register access control, Wishbone slave
//
// Design decisions made here: the register offsets and the Wishbone register port.
module ifs_format_switch
(
   input  wire logic                      clk_i,    // System clock
   input  wire logic                      rst_i,    // Sync reset, high
   input  wire logic                      cyc_i,    // Wishbone cycle
   input  wire logic                      stb_i,    // Wishbone strobe
   input  wire logic                      we_i,     // Wishbone write
   input  wire logic [ifs_pkg::ADR_W-1:0] adr_i,    // Byte address
   input  wire logic [ifs_pkg::SEL_W-1:0] sel_i,    // Byte enables
   input  wire logic [ifs_pkg::DAT_W-1:0] dat_i,    // Write data
   output logic      [ifs_pkg::DAT_W-1:0] dat_o,    // Read data
   output logic                           ack_o,    // Wishbone ack
   input  wire logic                      scl_i,    // Clock line pin
   output logic                           scl_o,    // Filtered line level
   output logic                           format_select_o,   // 1 formatless
   output logic                           latch_latch_reset_code_b0_o,   // Ch0 clear pulse
   output logic                           latch_latch_reset_code_b1_o,   // Ch1 clear pulse
   output logic                           switch_irq_o,   // Switch request
   output logic                           irq_o,          // Combined irq
   output logic      [7:0]                bus_ctrl_o,     // Control reg
   output logic      [7:0]                bus_stat_o,     // Status reg
   output logic      [7:0]                bus_data_o,     // Data reg
   output logic      [7:0]                bus_sadr2_o,    // Second address
   output logic      [7:0]                bus_mode_o,     // Mode reg
   output logic      [7:0]                bus_sadr_o      // Slave address
);

   // ==========================================================
   // Latch clear code decode, bit 0 channel zero, bit 1 channel one
   function automatic logic [1:0] clr_decode(input logic [3:0] code);
      logic [1:0] r;
      r = 2'b00;
      unique case (code)
         ifs_pkg::CODE_CH0:  r = 2'b01;
         ifs_pkg::CODE_CH1:  r = 2'b10;
         ifs_pkg::CODE_BOTH: r = 2'b11;
         default:            r = 2'b00;
      endcase
      return r;
   endfunction

   // Interface register offsets
   function automatic logic is_bank(input logic [4:0] a);
      return a == ifs_pkg::OFS_BUS_CTRL || a == ifs_pkg::OFS_BUS_STAT ||
             a == ifs_pkg::OFS_BUS_DATA || a == ifs_pkg::OFS_BUS_MODE;
   endfunction

   // ==========================================================
   // Internal signals
   ifs_pkg::ifs_bus_st_t          bus_st_ff;
   logic                          req;
   logic                          rd_stb;
   logic                          wr_stb;
   logic                          wr_b0;
   logic [7:0]                    byte_in;
   logic [ifs_pkg::CODE_W-1:0]    code_in;
   logic [ifs_pkg::DAT_W-1:0]     nxt_dat;
   logic [ifs_pkg::DAT_W-1:0]     dat_ff;
   logic                          acc_en_ff;
   logic                          swe_ff;
   logic                          sel_ff;
   logic                          ie_ff;
   logic                          flag_ff;
   logic                          sel_arm_ff;
   logic                          flag_arm_ff;
   logic                          fsw_wr;
   logic                          fsw_rd;
   logic                          scl_fall;
   logic                          auto_sw;
   logic [1:0]                    clr_hit;
   logic                          latch_reset_code_b0_ff;
   logic                          latch_reset_code_b1_ff;
   logic [ifs_pkg::STS_W-1:0]     sts_evt;
   logic [ifs_pkg::STS_W-1:0]     sts_ff;
   logic [ifs_pkg::STS_W-1:0]     msk_ff;
   logic                          bank_wr;
   logic [1:0]                    bank_idx;
   logic [7:0]                    bank_rdat;

   // ==========================================================
   // Wishbone slave, ack one cycle after the request is seen
   assign req     = cyc_i & stb_i;
   assign wr_stb  = req & we_i & (bus_st_ff == ifs_pkg::BUS_ACK);
   assign rd_stb  = req & ~we_i & (bus_st_ff == ifs_pkg::BUS_ACK);
   assign wr_b0   = wr_stb & sel_i[0];
   assign byte_in = dat_i[7:0];
   assign ack_o   = (bus_st_ff == ifs_pkg::BUS_ACK);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         bus_st_ff <= ifs_pkg::BUS_IDLE;
      else
      begin
         unique case (bus_st_ff)
            ifs_pkg::BUS_IDLE:
               if (req)
                  bus_st_ff <= ifs_pkg::BUS_ACK;
            ifs_pkg::BUS_ACK:
               bus_st_ff <= ifs_pkg::BUS_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Read data, captured in the cycle before ack
   always_comb
   begin
      nxt_dat = '0;
      unique case (adr_i)
         ifs_pkg::OFS_ACCESS:
            nxt_dat[ifs_pkg::ACC_EN_BIT] = acc_en_ff;
         ifs_pkg::OFS_FSW:
         begin
            nxt_dat[ifs_pkg::FSW_SWE_BIT]  = swe_ff;
            nxt_dat[ifs_pkg::FSW_SEL_BIT]  = sel_ff;
            nxt_dat[ifs_pkg::FSW_IE_BIT]   = ie_ff;
            nxt_dat[ifs_pkg::FSW_FLAG_BIT] = flag_ff;
            nxt_dat[ifs_pkg::FSW_CODE_LSB +: ifs_pkg::CODE_W] =
               ifs_pkg::CODE_RD;
         end
         ifs_pkg::OFS_IRQ_STS:
            nxt_dat[ifs_pkg::STS_W-1:0] = sts_ff;
         ifs_pkg::OFS_IRQ_MSK:
            nxt_dat[ifs_pkg::STS_W-1:0] = msk_ff;
         default:
            if (is_bank(adr_i) && acc_en_ff)
               nxt_dat[7:0] = bank_rdat;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_ff <= '0;
      else if (req && bus_st_ff == ifs_pkg::BUS_IDLE)
         dat_ff <= nxt_dat;
   end
   assign dat_o = dat_ff;

   // ==========================================================
   // Interface register access gate
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         acc_en_ff <= ifs_pkg::ACC_RST[ifs_pkg::ACC_EN_BIT];
      else if (wr_b0 && adr_i == ifs_pkg::OFS_ACCESS)
         acc_en_ff <= byte_in[ifs_pkg::ACC_EN_BIT];
   end

   // Blocked writes never reach the bank
   assign bank_wr  = wr_b0 & is_bank(adr_i) & acc_en_ff;
   assign bank_idx = adr_i[3:2];

   ifs_bus_regs ifs_bus_regs_inst
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clr_i   (latch_reset_code_b0_ff),
      .wr_i    (bank_wr),
      .idx_i   (bank_idx),
      .wdat_i  (byte_in),
      .rdat_o  (bank_rdat),
      .ctrl_o  (bus_ctrl_o),
      .stat_o  (bus_stat_o),
      .data_o  (bus_data_o),
      .sadr2_o (bus_sadr2_o),
      .mode_o  (bus_mode_o),
      .sadr_o  (bus_sadr_o)
   );

   // ==========================================================
   // Clock line edge detect
   ifs_scl_sync ifs_scl_sync_inst
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .scl_i   (scl_i),
      .level_o (scl_o),
      .fall_o  (scl_fall)
   );

   assign fsw_wr  = wr_b0 & (adr_i == ifs_pkg::OFS_FSW);
   assign fsw_rd  = rd_stb & (adr_i == ifs_pkg::OFS_FSW);
   assign auto_sw = scl_fall & swe_ff;
   assign code_in = byte_in[ifs_pkg::FSW_CODE_LSB +: ifs_pkg::CODE_W];

   // ==========================================================
   // Enable bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         swe_ff <= ifs_pkg::FSW_RST[ifs_pkg::FSW_SWE_BIT];
         ie_ff  <= ifs_pkg::FSW_RST[ifs_pkg::FSW_IE_BIT];
      end
      else if (fsw_wr)
      begin
         swe_ff <= byte_in[ifs_pkg::FSW_SWE_BIT];
         ie_ff  <= byte_in[ifs_pkg::FSW_IE_BIT];
      end
   end

   // ==========================================================
   // Format select, hardware clear wins over a software write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sel_ff <= ifs_pkg::FSW_RST[ifs_pkg::FSW_SEL_BIT];
      else if (auto_sw)
         sel_ff <= 1'b0;
      else if (fsw_wr)
      begin
         if (!byte_in[ifs_pkg::FSW_SEL_BIT])
            sel_ff <= 1'b0;
         else if (sel_arm_ff)
            sel_ff <= 1'b1;
      end
   end
   assign format_select_o = sel_ff;

   // Arms hold what software last read, the select arm inverted, taken from the returned word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sel_arm_ff  <= 1'b0;
         flag_arm_ff <= 1'b0;
      end
      else if (fsw_rd)
      begin
         sel_arm_ff  <= ~dat_ff[ifs_pkg::FSW_SEL_BIT];
         flag_arm_ff <= dat_ff[ifs_pkg::FSW_FLAG_BIT];
      end
      else if (fsw_wr)
      begin
         sel_arm_ff  <= 1'b0;
         flag_arm_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Switch event flag, a new event wins over a clearing write
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         flag_ff <= ifs_pkg::FSW_RST[ifs_pkg::FSW_FLAG_BIT];
      else if (auto_sw)
         flag_ff <= 1'b1;
      else if (fsw_wr && flag_arm_ff && !byte_in[ifs_pkg::FSW_FLAG_BIT])
         flag_ff <= 1'b0;
   end
   assign switch_irq_o = flag_ff & ie_ff;

   // ==========================================================
   // Latch clear pulses, one cycle per write
   assign clr_hit = clr_decode(code_in);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latch_reset_code_b0_ff <= 1'b0;
         latch_reset_code_b1_ff <= 1'b0;
      end
      else
      begin
         latch_reset_code_b0_ff <= fsw_wr & clr_hit[0];
         latch_reset_code_b1_ff <= fsw_wr & clr_hit[1];
      end
   end
   assign latch_latch_reset_code_b0_o = latch_reset_code_b0_ff;
   assign latch_latch_reset_code_b1_o = latch_reset_code_b1_ff;

   // ==========================================================
   // Interrupt status and mask, a new event wins over a clearing write
   always_comb
   begin
      sts_evt = '0;
      sts_evt[ifs_pkg::STS_SWITCH_BIT] = auto_sw;
      sts_evt[ifs_pkg::STS_CLEAR_BIT]  = latch_reset_code_b0_ff | latch_reset_code_b1_ff;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sts_ff <= ifs_pkg::STS_RST;
      else if (wr_b0 && adr_i == ifs_pkg::OFS_IRQ_STS)
         sts_ff <= (sts_ff & ~byte_in[ifs_pkg::STS_W-1:0]) | sts_evt;
      else
         sts_ff <= sts_ff | sts_evt;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         msk_ff <= ifs_pkg::MSK_RST;
      else if (wr_b0 && adr_i == ifs_pkg::OFS_IRQ_MSK)
         msk_ff <= byte_in[ifs_pkg::STS_W-1:0];
   end
   assign irq_o = |(sts_ff & msk_ff);

endmodule

// ---- core/ifs_pkg.sv ----
// Constants shared by the format switch control block
package ifs_pkg;

   // ==========================================================
   // Register bus
   localparam int unsigned ADR_W = 5;
   localparam int unsigned DAT_W = 32;
   localparam int unsigned SEL_W = 4;

   // ==========================================================
   // Register byte offsets
   localparam logic [4:0] OFS_ACCESS   = 5'h00;
   localparam logic [4:0] OFS_FSW      = 5'h04;
   localparam logic [4:0] OFS_IRQ_STS  = 5'h08;
   localparam logic [4:0] OFS_IRQ_MSK  = 5'h0C;
   localparam logic [4:0] OFS_BUS_CTRL = 5'h10;
   localparam logic [4:0] OFS_BUS_STAT = 5'h14;
   localparam logic [4:0] OFS_BUS_DATA = 5'h18;
   localparam logic [4:0] OFS_BUS_MODE = 5'h1C;

   // ==========================================================
   // Access control register fields
   localparam int unsigned ACC_EN_BIT  = 0;
   localparam logic [7:0]  ACC_RST     = 8'h00;

   // ==========================================================
   // Format switch control register fields
   localparam int unsigned FSW_SWE_BIT  = 7;
   localparam int unsigned FSW_SEL_BIT  = 6;
   localparam int unsigned FSW_IE_BIT   = 5;
   localparam int unsigned FSW_FLAG_BIT = 4;
   localparam int unsigned FSW_CODE_LSB = 0;
   localparam int unsigned CODE_W       = 4;
   localparam logic [7:0]  FSW_RST      = 8'h0F;
   localparam logic [3:0]  CODE_RD      = 4'hF;

   // Latch clear codes
   localparam logic [3:0] CODE_CH0  = 4'h5;
   localparam logic [3:0] CODE_CH1  = 4'h6;
   localparam logic [3:0] CODE_BOTH = 4'h7;

   // ==========================================================
   // Interrupt status and mask fields
   localparam int unsigned STS_SWITCH_BIT = 0;
   localparam int unsigned STS_CLEAR_BIT  = 1;
   localparam int unsigned STS_W          = 2;
   localparam logic [1:0]  STS_RST        = 2'h0;
   localparam logic [1:0]  MSK_RST        = 2'h0;

   // ==========================================================
   // Channel zero interface register bank
   localparam int unsigned BANK_SEL_BIT = 6;
   localparam logic [7:0]  BANK_RST     = 8'h00;

   // Bus slave states
   typedef enum logic [0:0]
   {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } ifs_bus_st_t;

endpackage

// ---- core/ifs_scl_sync.sv ----
// Clock line synchroniser with agreement filter and falling edge pulse
module ifs_scl_sync
(
   input  wire logic clk_i,    // System clock
   input  wire logic rst_i,    // Synchronous reset, active high
   input  wire logic scl_i,    // Clock line from the pin
   output logic      level_o,  // Filtered line level
   output logic      fall_o    // One-cycle pulse on falling edge
);

   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic level_ff;
   logic fall_ff;

   // ==========================================================
   // Three-stage capture
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_ff <= 1'b1;
         s2_ff <= 1'b1;
         s3_ff <= 1'b1;
      end
      else
      begin
         s1_ff <= scl_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // ==========================================================
   // Level changes only when the last two stages agree
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         level_ff <= 1'b1;
         fall_ff  <= 1'b0;
      end
      else
      begin
         fall_ff <= 1'b0;
         if (s2_ff == s3_ff)
         begin
            level_ff <= s3_ff;
            fall_ff  <= level_ff & ~s3_ff;
         end
      end
   end

   assign level_o = level_ff;
   assign fall_o  = fall_ff;

endmodule

// ---- core/ifs_bus_regs.sv ----
// Channel zero interface data and control register bank
module ifs_bus_regs
(
   input  wire logic       clk_i,    // System clock
   input  wire logic       rst_i,    // Synchronous reset, active high
   input  wire logic       clr_i,    // Latch clear pulse
   input  wire logic       wr_i,     // Write strobe, one cycle
   input  wire logic [1:0] idx_i,    // Register index in the bank
   input  wire logic [7:0] wdat_i,   // Write data
   output logic      [7:0] rdat_o,   // Read data, combinational
   output logic      [7:0] ctrl_o,   // Bus control register
   output logic      [7:0] stat_o,   // Bus status register
   output logic      [7:0] data_o,   // Bus data register
   output logic      [7:0] sadr2_o,  // Second slave address register
   output logic      [7:0] mode_o,   // Bus mode register
   output logic      [7:0] sadr_o    // Slave address register
);

   logic [7:0] regs_ff [6];
   logic       bank_alt;

   // Shared offsets pick the address registers when the bank bit is set
   assign bank_alt = regs_ff[0][ifs_pkg::BANK_SEL_BIT];

   // ==========================================================
   // Storage
   always_ff @(posedge clk_i)
   begin
      if (rst_i || clr_i)
      begin
         for (int i = 0; i < 6; i++)
            regs_ff[i] <= ifs_pkg::BANK_RST;
      end
      else if (wr_i)
      begin
         unique case (idx_i)
            2'd0: regs_ff[0] <= wdat_i;
            2'd1: regs_ff[1] <= wdat_i;
            2'd2:
               if (bank_alt)
                  regs_ff[3] <= wdat_i;
               else
                  regs_ff[2] <= wdat_i;
            2'd3:
               if (bank_alt)
                  regs_ff[5] <= wdat_i;
               else
                  regs_ff[4] <= wdat_i;
         endcase
      end
   end

   // ==========================================================
   // Read mux
   always_comb
   begin
      unique case (idx_i)
         2'd0: rdat_o = regs_ff[0];
         2'd1: rdat_o = regs_ff[1];
         2'd2: rdat_o = bank_alt ? regs_ff[3] : regs_ff[2];
         2'd3: rdat_o = bank_alt ? regs_ff[5] : regs_ff[4];
      endcase
   end

   assign ctrl_o  = regs_ff[0];
   assign stat_o  = regs_ff[1];
   assign data_o  = regs_ff[2];
   assign sadr2_o = regs_ff[3];
   assign mode_o  = regs_ff[4];
   assign sadr_o  = regs_ff[5];

endmodule

// ---- tb/ifs_format_switch_monitor.sv ----
// Port checker for the format switch block
module ifs_mon
(
   input wire logic clk_i,           // Clock
   input wire logic rst_i,           // Reset
   input wire logic we_i,            // Write
   input wire logic ack_o,           // Ack
   input wire logic scl_o,           // Line level
   input wire logic format_select_o, // Select
   input wire logic latch_latch_reset_code_b0_o,    // Clear 0
   input wire logic latch_latch_reset_code_b1_o,    // Clear 1
   input wire logic switch_irq_o     // Switch irq
);
   wire logic wr = ack_o && we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_C0_PULSE: assert property (latch_latch_reset_code_b0_o |=> !latch_latch_reset_code_b0_o)
      else $error("clear 0 too long");
   AST_C1_PULSE: assert property (latch_latch_reset_code_b1_o |=> !latch_latch_reset_code_b1_o)
      else $error("clear 1 too long");
   AST_CLR_SRC: assert property ((latch_latch_reset_code_b0_o || latch_latch_reset_code_b1_o) |->
      $past(wr) || $past(wr, 2)) else $error("clear without write");
   AST_SEL_SET: assert property ($rose(format_select_o) |->
      $past(wr) || $past(wr, 2)) else $error("select set alone");
   AST_SEL_CLR: assert property ($fell(format_select_o) |->
      $past(wr) || $past(wr, 2) || !scl_o) else $error("select cleared");
   AST_IRQ_OFF: assert property ($fell(switch_irq_o) |->
      $past(wr) || $past(wr, 2)) else $error("irq dropped alone");
   AST_IRQ_ON: assert property ($rose(switch_irq_o) |->
      !scl_o || $past(wr) || $past(wr, 2)) else $error("irq rose alone");
   AST_RST_VAL: assert property ($fell(rst_i) |->
      !format_select_o && !switch_irq_o) else $error("bad reset value");
   cover property ($fell(format_select_o) && !$past(wr));
   cover property (latch_latch_reset_code_b0_o && latch_latch_reset_code_b1_o);
   cover property ($rose(switch_irq_o));
endmodule
bind ifs_format_switch ifs_mon ifs_mon_inst (.clk_i(clk_i), .rst_i(rst_i),
   .we_i(we_i), .ack_o(ack_o), .scl_o(scl_o),
   .format_select_o(format_select_o), .latch_latch_reset_code_b0_o(latch_latch_reset_code_b0_o),
   .latch_latch_reset_code_b1_o(latch_latch_reset_code_b1_o), .switch_irq_o(switch_irq_o));

// ---- tb/ifs_scl_dev.sv ----
// Bus device model driving the clock line, idle high
module ifs_scl_dev
(
   input  wire logic go_i,  // Start a burst of pulses
   output logic      scl_o  // Clock line, pulled up
);
   timeunit 1ns;
   timeprecision 100ps;
   initial scl_o = 1'b1;
   always @(posedge go_i)
      repeat (3)
      begin
         #32 scl_o = 1'b0;
         #32 scl_o = 1'b1;
      end
endmodule

// ---- tb/ifs_format_switch_bench.sv ----
// Self-checking bench for the format switch block
module ifs_format_switch_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_i, rst_i, cyc, stb, we, go, s0, s1;
   logic [4:0]  adr;
   logic [31:0] dw, q;
   wire logic   scl, ack, fsel, c0, c1, sirq, irq;
   wire logic [31:0] dr;
   wire logic [7:0]  bctl;
   int          n_fail, checks_done, ncy;
   ifs_format_switch ifs_format_switch_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
      .dat_i(dw), .dat_o(dr), .ack_o(ack), .scl_i(scl), .scl_o(),
      .format_select_o(fsel), .latch_latch_reset_code_b0_o(c0), .latch_latch_reset_code_b1_o(c1),
      .switch_irq_o(sirq), .irq_o(irq), .bus_ctrl_o(bctl),
      .bus_stat_o(), .bus_data_o(), .bus_sadr2_o(), .bus_mode_o(),
      .bus_sadr_o());
   ifs_scl_dev ifs_scl_dev_inst (.go_i(go), .scl_o(scl));
   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i)
   begin
      ncy <= ncy + 1;
      if (c0) s0 <= 1'b1;
      if (c1) s1 <= 1'b1;
      if (ncy == 20000)
      begin
         n_fail++;
         report_and_stop;
      end
   end
   task report_and_stop;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task chkb(input string nm, input logic e, input logic g);
      chk(nm, {7'h0, e}, {7'h0, g});
   endtask
   task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
      n = 0;
      do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
      q = dr;
      cyc <= 1'b0; stb <= 1'b0;
      if (n == 50) chkb("ack", 1'b1, 1'b0);
   endtask
   task settle;
      repeat (4) @(posedge clk_i);
   endtask
   task scl_burst;
      go <= 1'b1;
      repeat (80) @(posedge clk_i);
      go <= 1'b0;
   endtask
   task t_reset;
      wb(0, 5'h04, 0); chk("fsw", 8'h0F, q[7:0]);
      wb(0, 5'h00, 0); chk("acc", 8'h00, q[7:0]);
      wb(1, 5'h10, 32'h5A); settle;
      chk("blk", 8'h00, bctl);
      wb(1, 5'h00, 1); wb(1, 5'h10, 32'h5A);
      wb(0, 5'h10, 0); chk("ctl", 8'h5A, q[7:0]);
   endtask
   task t_select;
      wb(1, 5'h04, 32'h0F); settle; chkb("sel", 0, fsel);
      wb(1, 5'h04, 32'h4F); settle; chkb("sel", 0, fsel);
      wb(0, 5'h04, 0); wb(1, 5'h04, 32'h4F);
      settle; chkb("sel", 1, fsel);
      wb(1, 5'h04, 32'h0F); settle; chkb("sel", 0, fsel);
   endtask
   task t_auto;
      wb(1, 5'h0C, 1); wb(0, 5'h04, 0); wb(1, 5'h04, 32'hEF);
      scl_burst;
      chkb("sel", 0, fsel);
      chkb("sirq", 1, sirq);
      chkb("irq", 1, irq);
      wb(0, 5'h08, 0); chk("sts", 8'h01, q[7:0]);
      wb(1, 5'h08, 1); settle; chkb("irq", 0, irq);
      wb(1, 5'h04, 32'hAF); settle; chkb("sirq", 1, sirq);
      wb(1, 5'h04, 32'h8F); settle; chkb("sirq", 0, sirq);
      wb(1, 5'h04, 32'hAF); settle; chkb("sirq", 1, sirq);
      wb(0, 5'h04, 0); wb(1, 5'h04, 32'h6F);
      settle; chkb("sirq", 0, sirq);
      scl_burst;
      chkb("sel", 1, fsel);
   endtask
   task t_clear;
      logic [3:0] cd [5];
      cd = '{4'h5, 4'h6, 4'h7, 4'hF, 4'h8};
      for (int i = 0; i < 5; i++)
      begin
         s0 = 1'b0;
         s1 = 1'b0;
         wb(1, 5'h04, {28'h0, cd[i]}); settle;
         chkb("latch_reset_code_b0", cd[i] == 4'h5 || cd[i] == 4'h7, s0);
         chkb("latch_reset_code_b1", cd[i] == 4'h6 || cd[i] == 4'h7, s1);
      end
      chk("bctl", 8'h00, bctl);
      wb(0, 5'h04, 0); chk("fsw", 8'h0F, q[7:0]);
      wb(0, 5'h08, 0); chk("sts", 8'h02, q[7:0]);
   endtask
   initial
   begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; go = 1'b0;
      adr = 5'h00; dw = 32'h0000_0000; s0 = 1'b0; s1 = 1'b0;
      n_fail = 0; checks_done = 0; ncy = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset; t_select; t_auto; t_clear;
      report_and_stop;
   end
endmodule
